/* aofs_consts.svh */
// Named offsets, field positions, reset values and bus codes of the
// auxiliary output selector.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef AOFS_CONSTS_SVH
`define AOFS_CONSTS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define AOFS_IDX_PIN_A_CONTROL 10'h01a
`define AOFS_IDX_PIN_B_CONTROL 10'h01b
`define AOFS_IDX_EVENT_STATUS 10'h01c
`define AOFS_IDX_EVENT_MASK 10'h01d
`define AOFS_IDX_LIVE_STATE 10'h01e

// ==========================================================================
// Pin control fields.
`define AOFS_FUNC_MSB 3
`define AOFS_FUNC_LSB 0
`define AOFS_INVERT_BIT 4
`define AOFS_CTRL_WIDTH 5
`define AOFS_CTRL_RESET 5'h00

// ==========================================================================
// Event status bits.
`define AOFS_EVT_WIDTH 5
`define AOFS_EVT_SLIP 0
`define AOFS_EVT_CRC_ERROR 1
`define AOFS_EVT_PRBS_ERROR 2
`define AOFS_EVT_SYNC_LOST 3
`define AOFS_EVT_TX_CLOCK_LOST 4
`define AOFS_EVT_RESET 5'h00

// ==========================================================================
// Live state register layout width.
`define AOFS_LIVE_WIDTH 10

// ==========================================================================
// AHB-Lite codes.
`define AOFS_HTRANS_NONSEQ_BIT 1
`define AOFS_HRESP_OKAY 1'b0
`define AOFS_HRDATA_RESET 32'h0000_0000

`endif

/* aofs_monitor.sv */
// Checker of the auxiliary output selector, watching only top-level ports.
// Assumes one AHB-Lite slave, pin A control at byte 0x68 and pin B at 0x6c.
`timescale 1ns/100ps

module aofs_monitor
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic RX_RECOVERED_CLOCK,
  input wire logic RX_SYNC_LOSS,
  input wire logic RX_CARRIER_LOSS,
  input wire logic RX_REMOTE_ALARM,
  input wire logic RX_ALL_ONES,
  input wire logic RX_SLIP_PULSE,
  input wire logic RX_CRC_ERROR_PULSE,
  input wire logic TX_CLOCK_LOSS,
  input wire logic RECOVERED_FRAME_PULSE,
  input wire logic RX_PRBS_ERROR_PULSE,
  input wire logic TX_NRZ_DATA,
  input wire logic RX_RAW_DATA,
  input wire logic RX_CRC4_MF_PULSE,
  input wire logic RX_CAS_MF_PULSE,
  input wire logic TX_CURRENT_LIMIT,
  input wire logic TX_POSITIVE_PULSES,
  input wire logic TX_NEGATIVE_PULSES,
  input wire logic AUX_OUT_A,
  input wire logic AUX_OUT_B,
  input wire logic IRQ
);
  logic wr_a;
  logic wr_b;
  logic [4:0] ca;
  logic [4:0] cb;
  logic [15:0] sa;
  logic [15:0] sb;

  // ==========================================================================
  // Shadow controls, rebuilt from observed writes so no internal probe is needed.
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      wr_a <= 1'b0;
      wr_b <= 1'b0;
      ca <= 5'h00;
      cb <= 5'h00;
    end
    else
    begin
      wr_a <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR == 32'h0000_0068;
      wr_b <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR == 32'h0000_006c;
      if (wr_a)
        ca <= HWDATA[4:0];
      if (wr_b)
        cb <= HWDATA[4:0];
    end
  end

  // Sources placed at the bit of their function code, bit 1 held zero instead of the clock; the CRC one is gated.
  assign sa = {TX_NEGATIVE_PULSES, TX_CURRENT_LIMIT, RX_CAS_MF_PULSE, RX_CRC4_MF_PULSE,
    RX_RAW_DATA, RX_PRBS_ERROR_PULSE, RECOVERED_FRAME_PULSE, TX_CLOCK_LOSS,
    RX_CRC_ERROR_PULSE & ~RX_SYNC_LOSS, RX_SLIP_PULSE, RX_ALL_ONES, RX_REMOTE_ALARM,
    RX_CARRIER_LOSS, RX_SYNC_LOSS, 2'b00};
  assign sb = {TX_POSITIVE_PULSES, sa[14:12], TX_NRZ_DATA, sa[10:0]};

  // ==========================================================================
  // Properties.
  default clocking dclk @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  property p_static_a;
    ca[3:0] == 4'h0 |=> AUX_OUT_A == $past(ca[4]);
  endproperty
  a_static_a: assert property (p_static_a) else $error("pin A static level wrong");

  property p_static_b;
    cb[3:0] == 4'h0 |=> AUX_OUT_B == $past(cb[4]);
  endproperty
  a_static_b: assert property (p_static_b) else $error("pin B static level wrong");

  property p_pin_a;
    ca[3:0] != 4'h1 |=> AUX_OUT_A == $past(sa[ca[3:0]] ^ ca[4]);
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A source wrong");

  property p_pin_b;
    cb[3:0] != 4'h1 |=> AUX_OUT_B == $past(sb[cb[3:0]] ^ cb[4]);
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin B source wrong");

  property p_rx_clock_a;
    (ca[3:0] == 4'h1 && $stable(ca))[*3] |-> AUX_OUT_A == ($past(RX_RECOVERED_CLOCK, 3) ^ ca[4]);
  endproperty
  a_rx_clock_a: assert property (p_rx_clock_a) else $error("pin A clock wrong");

  property p_crc_gate_a;
    RX_SYNC_LOSS && ca == 5'h07 |=> !AUX_OUT_A;
  endproperty
  a_crc_gate_a: assert property (p_crc_gate_a) else $error("CRC pin not held low");

  property p_slip_a;
    RX_SLIP_PULSE && ca == 5'h06 |=> AUX_OUT_A;
  endproperty
  a_slip_a: assert property (p_slip_a) else $error("slip pulse missing");

  property p_bus_okay;
    HSEL && HTRANS[1] |-> HREADYOUT && !HRESP;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response not ready and okay");

  c_slip: cover property (RX_SLIP_PULSE && ca == 5'h06);
  c_crc_gate: cover property (RX_SYNC_LOSS && RX_CRC_ERROR_PULSE && ca == 5'h07);
  c_irq: cover property ($rose(IRQ));
endmodule : aofs_monitor

bind aofs_top aofs_monitor i_mon (.*);

/* aofs_pin_sel.sv */
// One auxiliary output pin: picks a source by function code, then inverts.
// Assumes the caller places each source at the bit of its function code.
`timescale 1ns/100ps

module aofs_pin_sel
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] func,
  input wire logic invert,
  input wire aofs_pkg::aofs_src_t src,
  output logic pin
);

  logic selected;
  logic next_pin;

  // =======================================================================
  // Static code gives a zero source so the pin follows the invert bit.
  always_comb
  begin
    if (aofs_pkg::aofs_func_e'(func) == aofs_pkg::AOFS_FN_STATIC)
    begin
      selected = 1'b0; // see (R1)
    end
    else
    begin
      selected = src[func];
    end
    next_pin = selected ^ invert; // see (R15)
  end

  // Registered so the pin never glitches while the code is rewritten.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin <= 1'b0;
    end
    else
    begin
      pin <= next_pin;
    end
  end

endmodule : aofs_pin_sel

/* aofs_pin_watch.sv */
// Board-side watcher on the two auxiliary pins: counts rising edges seen.
// Assumes the board samples the pins on the same system clock as the block.
`timescale 1ns/100ps

module aofs_pin_watch
(
  input wire logic clk,
  input wire logic pin_a,
  input wire logic pin_b,
  output int rises_a,
  output int rises_b
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;

  // ==========================================================================
  // Edge counting; an unknown pin level never counts as a rise.
  initial
  begin
    rises_a = 0;
    rises_b = 0;
  end

  always @(posedge clk)
  begin
    if (pin_a === 1'b1 && !last_a)
      rises_a <= rises_a + 1;
    if (pin_b === 1'b1 && !last_b)
      rises_b <= rises_b + 1;
    last_a <= (pin_a === 1'b1);
    last_b <= (pin_b === 1'b1);
  end
endmodule : aofs_pin_watch

/* aofs_pkg.sv */
// Types shared by the auxiliary output selector modules.
// Assumes no other package; constants live in aofs_consts.svh.
package aofs_pkg;

  // ========================================================================
  // Function codes of one auxiliary output pin.
  typedef enum logic [3:0] {
    AOFS_FN_STATIC = 4'h0,
    AOFS_FN_RX_CLOCK = 4'h1,
    AOFS_FN_SYNC_LOSS = 4'h2,
    AOFS_FN_CARRIER_LOSS = 4'h3,
    AOFS_FN_REMOTE_ALARM = 4'h4,
    AOFS_FN_ALL_ONES = 4'h5,
    AOFS_FN_SLIP = 4'h6,
    AOFS_FN_CRC_ERROR = 4'h7,
    AOFS_FN_TX_CLOCK_LOSS = 4'h8,
    AOFS_FN_FRAME_PULSE = 4'h9,
    AOFS_FN_PRBS_ERROR = 4'ha,
    AOFS_FN_DATA_TAP = 4'hb,
    AOFS_FN_CRC4_MF = 4'hc,
    AOFS_FN_CAS_MF = 4'hd,
    AOFS_FN_CURRENT_LIMIT = 4'he,
    AOFS_FN_LINE_PULSES = 4'hf
  } aofs_func_e;

  typedef logic [15:0] aofs_src_t;

endpackage : aofs_pkg

/* aofs_sync2.sv */
// Two-stage synchroniser for levels arriving from outside the MCLK domain.
// Assumes the input changes slowly against MCLK.
`timescale 1ns/100ps

module aofs_sync2
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // =======================================================================
  // The first stage feeds only the second, so metastability cannot spread.
  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule : aofs_sync2

/* aofs_top.sv */
// Auxiliary output function selector of one transceiver, with AHB-Lite
// register access and an event interrupt.
// Assumes all status sources are MCLK-domain logic, except the recovered
// receive clock, which is synchronised here.
//
// Overview of operation
// (R1) Code zero drives the pin statically at the level of its invert bit.
// (R2) Code 0001 puts the recovered receive clock on the pin.
// (R3) Codes 0010-0101 show sync loss, carrier loss, remote alarm, all-ones live.
// (R4) Code 0110 gives a one-clock pulse per receive elastic store slip.
// (R5) Code 0111 pulses per CRC-errored multiframe, held low during sync loss.
// (R6) Code 1000 shows loss of transmit clock live.
// (R7) Code 1001 shows the recovered frame sync pulse.
// (R8) Code 1010 pulses for each bit error in the received test pattern.
// (R9) Code 1011: pin B shows transmit NRZ data, pin A raw receive data.
// (R10) Code 1100 shows CRC4 multiframe sync, code 1101 CAS multiframe sync.
// (R11) Code 1110 shows the transmit driver current-limit flag live.
// (R12) Code 1111: pin A negative pulses, pin B positive pulses of transmit line.
// (R13) Control bit 4 inverts the pin; bits 3 to 0 hold the function code.
// (R14) Pin A control sits at index 1A, pin B control at index 1B.
// (R15) Inversion applies after selection for every function code.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps

`include "aofs_consts.svh"

module aofs_top
(
  input wire logic MCLK,
  input wire logic RESETN,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Sources from the framer and line interface.
  input wire logic RX_RECOVERED_CLOCK,
  input wire logic RX_SYNC_LOSS,
  input wire logic RX_CARRIER_LOSS,
  input wire logic RX_REMOTE_ALARM,
  input wire logic RX_ALL_ONES,
  input wire logic RX_SLIP_PULSE,
  input wire logic RX_CRC_ERROR_PULSE,
  input wire logic TX_CLOCK_LOSS,
  input wire logic RECOVERED_FRAME_PULSE,
  input wire logic RX_PRBS_ERROR_PULSE,
  input wire logic TX_NRZ_DATA,
  input wire logic RX_RAW_DATA,
  input wire logic RX_CRC4_MF_PULSE,
  input wire logic RX_CAS_MF_PULSE,
  input wire logic TX_CURRENT_LIMIT,
  input wire logic TX_POSITIVE_PULSES,
  input wire logic TX_NEGATIVE_PULSES,
  // Pins and interrupt.
  output logic AUX_OUT_A,
  output logic AUX_OUT_B,
  output logic IRQ
);

  // =======================================================================
  // Declarations.
  logic rx_clock_sync;
  logic [`AOFS_CTRL_WIDTH-1:0] pin_a_control;
  logic [`AOFS_CTRL_WIDTH-1:0] pin_b_control;
  logic [`AOFS_CTRL_WIDTH-1:0] next_pin_a_control;
  logic [`AOFS_CTRL_WIDTH-1:0] next_pin_b_control;
  logic [`AOFS_EVT_WIDTH-1:0] event_status;
  logic [`AOFS_EVT_WIDTH-1:0] event_mask;
  logic [`AOFS_EVT_WIDTH-1:0] next_event_status;
  logic [`AOFS_EVT_WIDTH-1:0] next_event_mask;
  logic [`AOFS_EVT_WIDTH-1:0] events;
  logic [`AOFS_EVT_WIDTH-1:0] status_clear;
  logic next_irq;
  logic wr_pend;
  logic next_wr_pend;
  logic [9:0] wr_idx;
  logic [9:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic addr_ok;
  logic accept;
  logic rd_accept;
  logic [9:0] acc_idx;
  logic sync_loss_prev;
  logic tx_clock_loss_prev;
  logic next_sync_loss_prev;
  logic next_tx_clock_loss_prev;
  logic crc_gated;
  logic [`AOFS_LIVE_WIDTH-1:0] live_state;
  aofs_pkg::aofs_src_t src_a;
  aofs_pkg::aofs_src_t src_b;

  // =======================================================================
  // The recovered clock comes from the line, so it is resynchronised.
  // At 100 MHz the 2.048 MHz clock is still reproduced with small jitter.
  aofs_sync2 #(
    .WIDTH(1)
  ) u_rx_clock_sync (
    .clk(MCLK),
    .resetn(RESETN),
    .d(RX_RECOVERED_CLOCK),
    .q(rx_clock_sync)
  );

  // =======================================================================
  // Source vectors, one bit per function code.
  // The CRC error pulse is suppressed while receive sync is lost.
  assign crc_gated = RX_CRC_ERROR_PULSE & ~RX_SYNC_LOSS; // see (R5)

  always_comb
  begin
    src_a = '0;
    src_a[aofs_pkg::AOFS_FN_RX_CLOCK] = rx_clock_sync; // see (R2)
    src_a[aofs_pkg::AOFS_FN_SYNC_LOSS] = RX_SYNC_LOSS; // see (R3)
    src_a[aofs_pkg::AOFS_FN_CARRIER_LOSS] = RX_CARRIER_LOSS; // see (R3)
    src_a[aofs_pkg::AOFS_FN_REMOTE_ALARM] = RX_REMOTE_ALARM; // see (R3)
    src_a[aofs_pkg::AOFS_FN_ALL_ONES] = RX_ALL_ONES; // see (R3)
    src_a[aofs_pkg::AOFS_FN_SLIP] = RX_SLIP_PULSE; // see (R4)
    src_a[aofs_pkg::AOFS_FN_CRC_ERROR] = crc_gated; // see (R5)
    src_a[aofs_pkg::AOFS_FN_TX_CLOCK_LOSS] = TX_CLOCK_LOSS; // see (R6)
    src_a[aofs_pkg::AOFS_FN_FRAME_PULSE] = RECOVERED_FRAME_PULSE; // see (R7)
    src_a[aofs_pkg::AOFS_FN_PRBS_ERROR] = RX_PRBS_ERROR_PULSE; // see (R8)
    src_a[aofs_pkg::AOFS_FN_DATA_TAP] = RX_RAW_DATA; // see (R9)
    src_a[aofs_pkg::AOFS_FN_CRC4_MF] = RX_CRC4_MF_PULSE; // see (R10)
    src_a[aofs_pkg::AOFS_FN_CAS_MF] = RX_CAS_MF_PULSE; // see (R10)
    src_a[aofs_pkg::AOFS_FN_CURRENT_LIMIT] = TX_CURRENT_LIMIT; // see (R11)
    src_a[aofs_pkg::AOFS_FN_LINE_PULSES] = TX_NEGATIVE_PULSES; // see (R12)
  end

  // Pin B shares every source except the data tap and the line pulses.
  always_comb
  begin
    src_b = src_a;
    src_b[aofs_pkg::AOFS_FN_DATA_TAP] = TX_NRZ_DATA; // see (R9)
    src_b[aofs_pkg::AOFS_FN_LINE_PULSES] = TX_POSITIVE_PULSES; // see (R12)
  end

  // =======================================================================
  // Pin selectors; code in bits 3 to 0, invert in bit 4.
  aofs_pin_sel u_pin_a (
    .clk(MCLK),
    .resetn(RESETN),
    .func(pin_a_control[`AOFS_FUNC_MSB:`AOFS_FUNC_LSB]), // see (R13)
    .invert(pin_a_control[`AOFS_INVERT_BIT]), // see (R13)
    .src(src_a),
    .pin(AUX_OUT_A)
  );

  aofs_pin_sel u_pin_b (
    .clk(MCLK),
    .resetn(RESETN),
    .func(pin_b_control[`AOFS_FUNC_MSB:`AOFS_FUNC_LSB]), // see (R13)
    .invert(pin_b_control[`AOFS_INVERT_BIT]), // see (R13)
    .src(src_b),
    .pin(AUX_OUT_B)
  );

  // =======================================================================
  // AHB-Lite address phase decode. Only word indices below 1024 map; the
  // slave never inserts wait states, so HREADYOUT is constant high.
  assign HREADYOUT = 1'b1;
  assign HRESP = `AOFS_HRESP_OKAY;
  assign acc_idx = HADDR[11:2];
  assign addr_ok = (HADDR[31:12] == 20'h00000);
  assign accept = HSEL & HTRANS[`AOFS_HTRANS_NONSEQ_BIT] & HREADY;
  assign rd_accept = accept & ~HWRITE & addr_ok;

  always_comb
  begin
    next_wr_pend = accept & HWRITE & addr_ok;
    next_wr_idx = acc_idx;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 10'h000;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
    end
  end

  // =======================================================================
  // Control and mask registers are written in the write data phase.
  always_comb
  begin
    next_pin_a_control = pin_a_control;
    next_pin_b_control = pin_b_control;
    next_event_mask = event_mask;
    if (wr_pend)
    begin
      case (wr_idx)
        `AOFS_IDX_PIN_A_CONTROL: next_pin_a_control = HWDATA[`AOFS_CTRL_WIDTH-1:0]; // see (R14)
        `AOFS_IDX_PIN_B_CONTROL: next_pin_b_control = HWDATA[`AOFS_CTRL_WIDTH-1:0]; // see (R14)
        `AOFS_IDX_EVENT_MASK: next_event_mask = HWDATA[`AOFS_EVT_WIDTH-1:0];
        default: next_event_mask = event_mask;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      pin_a_control <= `AOFS_CTRL_RESET;
      pin_b_control <= `AOFS_CTRL_RESET;
      event_mask <= `AOFS_EVT_RESET;
    end
    else
    begin
      pin_a_control <= next_pin_a_control;
      pin_b_control <= next_pin_b_control;
      event_mask <= next_event_mask;
    end
  end

  // =======================================================================
  // Event capture: pulses set their bits directly, levels on rising edge.
  always_comb
  begin
    next_sync_loss_prev = RX_SYNC_LOSS;
    next_tx_clock_loss_prev = TX_CLOCK_LOSS;
    events = '0;
    events[`AOFS_EVT_SLIP] = RX_SLIP_PULSE;
    events[`AOFS_EVT_CRC_ERROR] = crc_gated;
    events[`AOFS_EVT_PRBS_ERROR] = RX_PRBS_ERROR_PULSE;
    events[`AOFS_EVT_SYNC_LOST] = RX_SYNC_LOSS & ~sync_loss_prev;
    events[`AOFS_EVT_TX_CLOCK_LOST] = TX_CLOCK_LOSS & ~tx_clock_loss_prev;
  end

  // A read of the status register clears it; an event in that very
  // cycle still sets its bit, so no event is ever lost to a read.
  always_comb
  begin
    status_clear = '0;
    if (rd_accept && acc_idx == `AOFS_IDX_EVENT_STATUS)
    begin
      status_clear = '1;
    end
    next_event_status = (event_status & ~status_clear) | events;
    next_irq = |(next_event_status & next_event_mask);
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      sync_loss_prev <= 1'b0;
      tx_clock_loss_prev <= 1'b0;
      event_status <= `AOFS_EVT_RESET;
      IRQ <= 1'b0;
    end
    else
    begin
      sync_loss_prev <= next_sync_loss_prev;
      tx_clock_loss_prev <= next_tx_clock_loss_prev;
      event_status <= next_event_status;
      IRQ <= next_irq;
    end
  end

  // =======================================================================
  // Live state: the level inputs as they stand now, both pins, rx_clock_sync and wr_pend, for polling software.
  assign live_state = {TX_CURRENT_LIMIT, TX_CLOCK_LOSS, RX_ALL_ONES,
                       RX_REMOTE_ALARM, RX_CARRIER_LOSS, RX_SYNC_LOSS,
                       AUX_OUT_B, AUX_OUT_A, rx_clock_sync, wr_pend};

  // =======================================================================
  // Read data is registered in the address phase and stands in the data
  // phase. A read right after a write to the same register sees the new
  // value, because the pending write data is forwarded.
  always_comb
  begin
    next_hrdata = HRDATA;
    if (rd_accept)
    begin
      next_hrdata = `AOFS_HRDATA_RESET;
      case (acc_idx)
        `AOFS_IDX_PIN_A_CONTROL:
        begin
          if (wr_pend && wr_idx == acc_idx)
          begin
            next_hrdata[`AOFS_CTRL_WIDTH-1:0] = HWDATA[`AOFS_CTRL_WIDTH-1:0];
          end
          else
          begin
            next_hrdata[`AOFS_CTRL_WIDTH-1:0] = pin_a_control;
          end
        end
        `AOFS_IDX_PIN_B_CONTROL:
        begin
          if (wr_pend && wr_idx == acc_idx)
          begin
            next_hrdata[`AOFS_CTRL_WIDTH-1:0] = HWDATA[`AOFS_CTRL_WIDTH-1:0];
          end
          else
          begin
            next_hrdata[`AOFS_CTRL_WIDTH-1:0] = pin_b_control;
          end
        end
        `AOFS_IDX_EVENT_STATUS: next_hrdata[`AOFS_EVT_WIDTH-1:0] = event_status;
        `AOFS_IDX_EVENT_MASK:
        begin
          if (wr_pend && wr_idx == acc_idx)
          begin
            next_hrdata[`AOFS_EVT_WIDTH-1:0] = HWDATA[`AOFS_EVT_WIDTH-1:0];
          end
          else
          begin
            next_hrdata[`AOFS_EVT_WIDTH-1:0] = event_mask;
          end
        end
        `AOFS_IDX_LIVE_STATE: next_hrdata[`AOFS_LIVE_WIDTH-1:0] = live_state;
        default: next_hrdata = `AOFS_HRDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      HRDATA <= `AOFS_HRDATA_RESET;
    end
    else
    begin
      HRDATA <= next_hrdata;
    end
  end

endmodule : aofs_top

/* aux_output_function_select_tb.sv */
// Self-checking bench of the auxiliary output selector with a pin watcher.
// Assumes aofs_top as the design and aofs_pin_watch as the board side.
`timescale 1ns/100ps

module aux_output_function_select_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [17:0] src = 18'h0;
  logic [17:0] nxt;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, pin_a, pin_b, irq;
  logic [17:0] hist[$];
  int rises_a, rises_b, ra;
  int fails = 0;
  int num_checks = 0;

  // ==========================================================================
  // Clock, design and board side; src bit n feeds the source of code n, but pin A's codes 11 and 15 take bits 16 and 17.
  always #5 mclk = ~mclk;

  aofs_top i_dut (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RX_RECOVERED_CLOCK(src[1]),
    .RX_SYNC_LOSS(src[2]), .RX_CARRIER_LOSS(src[3]), .RX_REMOTE_ALARM(src[4]),
    .RX_ALL_ONES(src[5]), .RX_SLIP_PULSE(src[6]), .RX_CRC_ERROR_PULSE(src[7]),
    .TX_CLOCK_LOSS(src[8]), .RECOVERED_FRAME_PULSE(src[9]), .RX_PRBS_ERROR_PULSE(src[10]),
    .TX_NRZ_DATA(src[11]), .RX_RAW_DATA(src[16]), .RX_CRC4_MF_PULSE(src[12]),
    .RX_CAS_MF_PULSE(src[13]), .TX_CURRENT_LIMIT(src[14]), .TX_POSITIVE_PULSES(src[15]),
    .TX_NEGATIVE_PULSES(src[17]), .AUX_OUT_A(pin_a), .AUX_OUT_B(pin_b), .IRQ(irq));

  aofs_pin_watch i_watch (.clk(mclk), .pin_a(pin_a), .pin_b(pin_b), .rises_a(rises_a),
    .rises_b(rises_b));

  // ==========================================================================
  // Comparison, verdict and bus tasks.
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Waits for ready under a bound, so a stuck slave ends the run.
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      summarize();
    end
  endtask : wait_ready

  // One single-word transfer; entered just after a rising edge.
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rd_chk

  // Reference pin level; s2 is the source vector two edges older for the clock.
  function automatic logic model(int c, logic [17:0] s, logic [17:0] s2, bit b);
    logic v;
    case (c % 16)
      0: v = 1'b0;
      1: v = s2[1];
      7: v = s[7] & ~s[2];
      11: v = b ? s[11] : s[16];
      15: v = b ? s[15] : s[17];
      default: v = s[c % 16];
    endcase
    return v ^ c[4];
  endfunction : model

  // ==========================================================================
  // Main sequence.
  initial
  begin
    ra = $urandom(32'h96f3);
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd_chk("ctrl_a_reset", 32'h68, 32'h0);
    rd_chk("ctrl_b_reset", 32'h6c, 32'h0);
    ahb(1'b1, 32'h68, 32'hffff_ffff);
    rd_chk("ctrl_a_bits", 32'h68, 32'h1f);
    ahb(1'b1, 32'h100, 32'h3);
    rd_chk("unmapped", 32'h100, 32'h0);
    rd_chk("ctrl_b_kept", 32'h6c, 32'h0);
    // Code zero: raising the invert bit alone must give the board one rise.
    ahb(1'b1, 32'h68, 32'h0);
    repeat (2) @(posedge mclk);
    ra = rises_a;
    ahb(1'b1, 32'h68, 32'h10);
    repeat (3) @(posedge mclk);
    #1;
    chk("static_rise", 32'(rises_a - ra), 32'h1);
    chk("static_level", {31'h0, pin_a}, 32'h1);
    @(posedge mclk);
    // Every code and invert on A, the mirrored code on B, random sources.
    for (int c = 0; c < 32; c++)
    begin
      ahb(1'b1, 32'h68, 32'(c));
      ahb(1'b1, 32'h6c, 32'(31 - c));
      repeat (2) @(posedge mclk);
      hist = '{src, src, src, src};
      for (int k = 0; k < 24; k++)
      begin
        @(posedge mclk);
        nxt = 18'($urandom) & ~(src & 18'h004c0);
        src <= nxt;
        #1;
        hist.push_front(nxt);
        hist.pop_back();
        chk("pin_a", {31'h0, pin_a}, {31'h0, model(c, hist[1], hist[3], 1'b0)});
        chk("pin_b", {31'h0, pin_b}, {31'h0, model(31 - c, hist[1], hist[3], 1'b1)});
      end
    end
    // Interrupt: unmasked slip raises it, a status read clears it, PRBS stays masked.
    @(posedge mclk);
    src <= 18'h0;
    ahb(1'b0, 32'h70, 32'h0);
    ahb(1'b1, 32'h74, 32'h1);
    src <= 18'h00440;
    @(posedge mclk);
    src <= 18'h0;
    #1;
    chk("irq_set", {31'h0, irq}, 32'h1);
    @(posedge mclk);
    rd_chk("status_both", 32'h70, 32'h5);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    src <= 18'h00400;
    @(posedge mclk);
    src <= 18'h0;
    #1;
    chk("irq_masked", {31'h0, irq}, 32'h0);
    @(posedge mclk);
    rd_chk("status_prbs", 32'h70, 32'h4);
    summarize();
  end
endmodule : aux_output_function_select_tb
